// ### hdl/pwm_unit_regs.svh
// Register offsets, field positions, reset values and widths of the PWM unit
`ifndef PWM_UNIT_REGS_SVH
`define PWM_UNIT_REGS_SVH

// Byte offsets of the 32-bit register words
`define OFS_COUNT 8'h00
`define OFS_DUTY 8'h04
`define OFS_CTRL 8'h08
`define OFS_ACTIVE 8'h0c
`define OFS_MODE 8'h10

// Control word: low byte pwm_control_c, high byte compare_force
`define PPR_MSB 2
`define PPR_LSB 0
`define SF_B_BIT 4
`define SF_A_BIT 5
`define FORCE_A_BIT 8
`define FORCE_B_BIT 9

// Mode word
`define EN_A_BIT 0
`define EN_B_BIT 1
`define CLKOUT_BIT 2

// Duty and active-duty words: channel a in the upper byte
`define CH_A_MSB 15
`define CH_A_LSB 8
`define CH_B_MSB 7
`define CH_B_LSB 0

// Selector values and counter windows
`define PPR_EXT 3'h7
`define FAST_LSB 0
`define SLOW_LSB 7
`define FAST_END 15'h00ff
`define SLOW_END 15'h7fff
`define FAST_MASK 15'h00ff

// Reset values
`define COUNT_RST 16'h0000
`define DUTY_RST 8'h00
`define CTRL_RST 8'h00

`endif

// ### hdl/pwm_unit_pkg.sv
// Types shared by the PWM unit
package pwm_unit_pkg;

  // One PWM channel: software duty, active duty, force bits and pin
  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] active;
    logic force_req;
    logic force_live;
    logic pin;
  } chan_t;

  // Entire state of the unit
  typedef struct packed {
    chan_t a;
    chan_t b;
    logic [15:0] count;
    logic [6:0] presc;
    logic [2:0] ppr;
    logic sf_a;
    logic sf_b;
    logic [2:0] mode;
    logic [2:0] ext_sync;
    logic ext_level;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pwm_state_t;

endpackage

// ### hdl/dual_channel_pwm_unit.sv
// Two-channel PWM unit with shared prescaled counter, APB register access
//
// Overview of operation
// RULE1 - After reset the counter runs from system clock divided by two.
// RULE2 - Software picks one of seven prescaler taps or the external clock pin.
// RULE3 - Counter reads never disturb it; a word read is coherent.
// RULE4 - Counter clears on reset; writes accepted only in freeze or test mode.
// RULE5 - Fifteen counter bits feed both channels; per-channel slow/fast bit.
// RULE6 - Fast mode uses count bits 7..0, slow mode bits 14..7.
// RULE7 - Slow period is exactly 128 fast periods.
// RULE8 - Select 000 divides by 2, doubling to 128 at 110; 111 is external.
// RULE9 - Output rate is counter clock over 256 fast, over 32768 slow.
// RULE10 - Duty zero is always low; duty N is high for N/256 of period.
// RULE11 - Duty registers reachable as single bytes or one 16-bit word.
// RULE12 - Force-high gives continuous high, starting when current cycle ends.
// RULE13 - New duty is copied to the active buffer at cycle end.
// RULE14 - Duty and control registers reset to zero, always read/write.
// RULE15 - Control byte low, compare-force byte high; force bits lowest two.
// RULE16 - Active duty buffers are read-only, byte or word access.
// RULE17 - With PWM disabled, force bits drive the pins; reads return pins.
// RULE18 - Channel a pin may output the counter clock instead.
// RULE19 - Pin high while selected eight count bits are below active duty.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`include "pwm_unit_regs.svh"

module dual_channel_pwm_unit
  import pwm_unit_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device mode straps from system logic
  input wire logic freeze_mode,
  input wire logic test_mode,
  // External counter clock pin, asynchronous
  input wire logic ext_clk_pin,
  // PWM pins
  output logic pwm_pin_a,
  output logic pwm_pin_b
);

  pwm_state_t st;
  pwm_state_t next_st;
  logic tick;
  logic ext_rise;
  logic cyc_end_a;
  logic cyc_end_b;
  logic access;
  logic wr_now;
  logic count_wr_ok;
  logic clk_level;

  // Prescaler tap strobe: tap k fires once every 2^(k+1) system clocks
  // The divider is never cleared on a select change, so the first tick after
  // a change may come early; later ticks keep the exact tap rate
  function automatic logic tap_tick(input logic [6:0] presc, input logic [2:0] sel);
    logic [7:0] mask;
    mask = (8'h02 << sel) - 8'h01;
    return &(presc | ~mask[6:0]);
  endfunction

  // Eight count bits that a channel compares against
  function automatic logic [7:0] duty_slice(input logic [15:0] cnt, input logic slow);
    return slow ? cnt[`SLOW_LSB +: 8] : cnt[`FAST_LSB +: 8];
  endfunction

  // Last count of a PWM period: 256 counts fast, 32768 counts slow
  function automatic logic period_end(input logic [15:0] cnt, input logic slow);
    return slow ? (cnt[14:0] == `SLOW_END) : ((cnt[14:0] & `FAST_MASK) == `FAST_END);
  endfunction

  // Byte-lane merge of a 16-bit field; bytes not strobed keep their value
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // One channel's next state: buffer load at period end and pin level
  function automatic chan_t chan_next(input chan_t c, input logic [15:0] cnt,
                                      input logic slow, input logic at_end,
                                      input logic enable, input logic clk_sel,
                                      input logic clk_lvl);
    chan_t r;
    r = c;
    // RULE13 buffer at period end
    // RULE12 force takes hold at period end
    if (at_end) begin
      r.active = c.duty;
      r.force_live = c.force_req;
    end
    // RULE17 pin as plain output
    if (!enable) begin
      r.pin = c.force_req;
    // RULE18 counter clock out
    end else if (clk_sel) begin
      r.pin = clk_lvl;
    end else if (c.force_live) begin
      r.pin = 1'b1;
    end else begin
      // RULE19 compare each count
      // RULE10 zero duty never high
      r.pin = duty_slice(cnt, slow) < c.active;
    end
    return r;
  endfunction

  // Address decode of mapped words
  function automatic logic addr_known(input logic [7:0] a);
    return (a == `OFS_COUNT) || (a == `OFS_DUTY) || (a == `OFS_CTRL) ||
           (a == `OFS_ACTIVE) || (a == `OFS_MODE);
  endfunction

  assign access = psel & penable;
  assign wr_now = access & st.pready & pwrite;
  assign count_wr_ok = freeze_mode | test_mode;

  // Next-state logic for counter, channels and register slave
  always_comb begin
    next_st = st;
    next_st.presc = st.presc + 7'h01;
    // Pin synchroniser: stage 0 feeds stage 1 only; stages 1 and 2 vote
    next_st.ext_sync = {st.ext_sync[1:0], ext_clk_pin};
    ext_rise = 1'b0;
    if ((st.ext_sync[1] == st.ext_sync[2]) && (st.ext_sync[2] != st.ext_level)) begin
      next_st.ext_level = st.ext_sync[2];
      ext_rise = st.ext_sync[2];
    end
    // RULE8 tap select map
    // RULE2 tap or external pin
    // RULE1 divide by two after reset
    if (st.ppr == `PPR_EXT) begin
      tick = ext_rise;
      clk_level = st.ext_level;
    end else begin
      tick = tap_tick(st.presc, st.ppr);
      clk_level = st.presc[st.ppr];
    end
    // RULE5 shared counter, per-channel mode
    if (tick) begin
      next_st.count = st.count + 16'h0001;
    end
    // RULE7 slow is 128 fast periods
    // RULE9 period 256 or 32768 counts
    cyc_end_a = tick & period_end(st.count, st.sf_a);
    cyc_end_b = tick & period_end(st.count, st.sf_b);
    // RULE6 fast or slow window
    next_st.a = chan_next(st.a, st.count, st.sf_a, cyc_end_a, st.mode[`EN_A_BIT],
                          st.mode[`CLKOUT_BIT], clk_level);
    next_st.b = chan_next(st.b, st.count, st.sf_b, cyc_end_b, st.mode[`EN_B_BIT],
                          1'b0, clk_level);

    // APB: one wait state, answer registered at end of first access cycle
    // Trade-off: the wait state buys a registered prdata and a count snapshot
    // taken at one edge, so a word read of the counter is always coherent
    next_st.pready = access & ~st.pready;
    if (access & ~st.pready) begin
      next_st.pslverr = ~addr_known(paddr);
      next_st.prdata = 32'h0000_0000;
      // RULE3 coherent count read
      if (paddr == `OFS_COUNT) begin
        next_st.prdata[15:0] = st.count;
      // RULE11 duty word
      end else if (paddr == `OFS_DUTY) begin
        next_st.prdata[15:0] = {st.a.duty, st.b.duty};
      // RULE15 control and force word
      end else if (paddr == `OFS_CTRL) begin
        next_st.prdata[`PPR_MSB:`PPR_LSB] = st.ppr;
        next_st.prdata[`SF_B_BIT] = st.sf_b;
        next_st.prdata[`SF_A_BIT] = st.sf_a;
        // RULE17 force bits read pins
        next_st.prdata[`FORCE_A_BIT] = st.a.pin;
        next_st.prdata[`FORCE_B_BIT] = st.b.pin;
      // RULE16 read-only buffers
      end else if (paddr == `OFS_ACTIVE) begin
        next_st.prdata[15:0] = {st.a.active, st.b.active};
      end else if (paddr == `OFS_MODE) begin
        next_st.prdata[2:0] = st.mode;
      end
    end else if (!access) begin
      next_st.pslverr = 1'b0;
    end

    // Writes land at the edge where the master sees pready high
    if (wr_now) begin
      // RULE4 count writable only in freeze or test
      if (paddr == `OFS_COUNT) begin
        if (count_wr_ok) begin
          next_st.count = merge16(st.count, pwdata[15:0], pstrb[1:0]);
        end
      // RULE11 byte or word duty write
      end else if (paddr == `OFS_DUTY) begin
        {next_st.a.duty, next_st.b.duty} =
          merge16({st.a.duty, st.b.duty}, pwdata[15:0], pstrb[1:0]);
      // RULE14 control writable any time
      end else if (paddr == `OFS_CTRL) begin
        if (pstrb[0]) begin
          next_st.ppr = pwdata[`PPR_MSB:`PPR_LSB];
          next_st.sf_b = pwdata[`SF_B_BIT];
          next_st.sf_a = pwdata[`SF_A_BIT];
        end
        // RULE15 force bits in high byte
        if (pstrb[1]) begin
          next_st.a.force_req = pwdata[`FORCE_A_BIT];
          next_st.b.force_req = pwdata[`FORCE_B_BIT];
        end
      end else if (paddr == `OFS_MODE) begin
        if (pstrb[0]) begin
          next_st.mode = pwdata[2:0];
        end
      end
    end
  end

  // State register; every field resets to zero
  // RULE14 zero reset values
  // RULE4 count clears on reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign pwm_pin_a = st.a.pin;
  assign pwm_pin_b = st.b.pin;

  // Zero active duty keeps channel b low while it is enabled and unforced
  a_duty_zero_low: assert property ( // RULE10
    @(posedge clk_sys) disable iff (sys_rst)
    (st.mode[`EN_B_BIT] && !st.b.force_live && st.b.active == `DUTY_RST) |=> !pwm_pin_b)
    else $error("channel b high with zero duty");

  a_force_high_hold: assert property ( // RULE12
    @(posedge clk_sys) disable iff (sys_rst)
    (st.mode[`EN_A_BIT] && !st.mode[`CLKOUT_BIT] && st.a.force_live) [*2] |=> pwm_pin_a)
    else $error("forced channel a not high");

  a_buffer_end_only: assert property ( // RULE13
    @(posedge clk_sys) disable iff (sys_rst)
    !cyc_end_a |=> (st.a.active == $past(st.a.active)))
    else $error("active duty a changed mid period");

  a_buffer_takes_duty: assert property ( // RULE13
    @(posedge clk_sys) disable iff (sys_rst)
    cyc_end_b |=> (st.b.active == $past(st.b.duty)))
    else $error("active duty b not loaded at period end");

  a_count_readonly: assert property ( // RULE4
    @(posedge clk_sys) disable iff (sys_rst)
    !count_wr_ok |=> (st.count == $past(st.count) ||
                      st.count == $past(st.count) + 16'h0001))
    else $error("count moved other than by one");

  a_count_reset_zero: assert property ( // RULE4
    @(posedge clk_sys)
    sys_rst |=> (st.count == `COUNT_RST && st.ppr == 3'h0))
    else $error("count or select not cleared by reset");

  a_div2_tick: assert property ( // RULE1
    @(posedge clk_sys) disable iff (sys_rst)
    (st.ppr == 3'h0 && !wr_now) |=> (tick != $past(tick)))
    else $error("divide by two tap not alternating");

  a_gpio_drive: assert property ( // RULE17
    @(posedge clk_sys) disable iff (sys_rst)
    !st.mode[`EN_B_BIT] |=> (pwm_pin_b == $past(st.b.force_req)))
    else $error("pin b not following force bit");

  a_apb_answer: assert property ( // RULE3
    @(posedge clk_sys) disable iff (sys_rst)
    (access && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one cycle after access");

  a_unmapped_err: assert property ( // RULE3
    @(posedge clk_sys) disable iff (sys_rst)
    (access && !pready && !addr_known(paddr)) |=> (pslverr && pready))
    else $error("unmapped address not flagged");

  // Counter checks: it moves only on a tick or on a permitted write
  a_count_step: assert property ( // RULE5
    @(posedge clk_sys) disable iff (sys_rst)
    (tick && !wr_now) |=> (st.count == $past(st.count) + 16'h0001))
    else $error("count missed a tick");

  a_count_idle: assert property ( // RULE2
    @(posedge clk_sys) disable iff (sys_rst)
    (!tick && !wr_now) |=> (st.count == $past(st.count)))
    else $error("count moved without a tick");

  a_count_write: assert property ( // RULE4
    @(posedge clk_sys) disable iff (sys_rst)
    (wr_now && paddr == `OFS_COUNT && count_wr_ok && pstrb[1:0] == 2'h3) |=>
      (st.count == 16'($past(pwdata))))
    else $error("permitted count write lost");

  a_ext_tick_gap: assert property ( // RULE2
    @(posedge clk_sys) disable iff (sys_rst)
    (st.ppr == `PPR_EXT && tick && !wr_now) |=> !tick)
    else $error("external clock ticked twice in a row");

  // Channel checks: compare window of channel b, zero duty of channel a, buffer timing of both channels, force timing and pin drive of channel a, pin readback
  a_fast_high: assert property ( // RULE19
    @(posedge clk_sys) disable iff (sys_rst)
    (st.mode[`EN_B_BIT] && !st.sf_b && !st.b.force_live &&
     st.count[`FAST_LSB +: 8] < st.b.active) |=> pwm_pin_b)
    else $error("fast channel b low below duty");

  a_fast_low: assert property ( // RULE19
    @(posedge clk_sys) disable iff (sys_rst)
    (st.mode[`EN_B_BIT] && !st.sf_b && !st.b.force_live &&
     st.count[`FAST_LSB +: 8] >= st.b.active) |=> !pwm_pin_b)
    else $error("fast channel b high at or above duty");

  a_slow_high: assert property ( // RULE6
    @(posedge clk_sys) disable iff (sys_rst)
    (st.mode[`EN_B_BIT] && st.sf_b && !st.b.force_live &&
     st.count[`SLOW_LSB +: 8] < st.b.active) |=> pwm_pin_b)
    else $error("slow channel b low below duty");

  a_slow_low: assert property ( // RULE6
    @(posedge clk_sys) disable iff (sys_rst)
    (st.mode[`EN_B_BIT] && st.sf_b && !st.b.force_live &&
     st.count[`SLOW_LSB +: 8] >= st.b.active) |=> !pwm_pin_b)
    else $error("slow channel b high at or above duty");

  a_duty_zero_a: assert property ( // RULE10
    @(posedge clk_sys) disable iff (sys_rst)
    (st.mode[`EN_A_BIT] && !st.mode[`CLKOUT_BIT] && !st.a.force_live &&
     st.a.active == `DUTY_RST) |=> !pwm_pin_a)
    else $error("channel a high with zero duty");

  a_gpio_drive_a: assert property ( // RULE17
    @(posedge clk_sys) disable iff (sys_rst)
    !st.mode[`EN_A_BIT] |=> (pwm_pin_a == $past(st.a.force_req)))
    else $error("pin a not following force bit");

  a_buffer_end_b: assert property ( // RULE13
    @(posedge clk_sys) disable iff (sys_rst)
    !cyc_end_b |=> (st.b.active == $past(st.b.active)))
    else $error("active duty b changed mid period");

  a_buffer_takes_a: assert property ( // RULE13
    @(posedge clk_sys) disable iff (sys_rst)
    cyc_end_a |=> (st.a.active == $past(st.a.duty)))
    else $error("active duty a not loaded at period end");

  a_force_end_only: assert property ( // RULE12
    @(posedge clk_sys) disable iff (sys_rst)
    !cyc_end_a |=> (st.a.force_live == $past(st.a.force_live)))
    else $error("force on channel a took hold mid period");

  a_pin_readback: assert property ( // RULE17
    @(posedge clk_sys) disable iff (sys_rst)
    (access && !pready && paddr == `OFS_CTRL) |=>
      (prdata[`FORCE_A_BIT] == $past(pwm_pin_a) &&
       prdata[`FORCE_B_BIT] == $past(pwm_pin_b)))
    else $error("force bits do not read pin levels");

endmodule

// ### verification/dual_channel_pwm_unit_tb.sv
// Self-checking testbench of the dual-channel PWM unit
`include "pwm_unit_regs.svh"

module dual_channel_pwm_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [2:0] ppr;
    logic [7:0] duty;
    logic [15:0] high;
  } row_t;

  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic freeze_mode = 1'b0;
  logic test_mode = 1'b0;
  logic ext_clk_pin = 1'b0;
  logic pwm_pin_a;
  logic pwm_pin_b;
  logic [31:0] rv;
  logic ev;
  logic [15:0] c0;
  logic pv;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int per;
  int h;
  int n;
  // Channel b cases: prescaler tap, duty and high clocks in one period
  row_t rows [5] = '{'{3'h0, 8'h00, 16'h0000}, '{3'h0, 8'h80, 16'h0100},
                     '{3'h0, 8'hff, 16'h01fe}, '{3'h1, 8'h40, 16'h0100},
                     '{3'h2, 8'h01, 16'h0008}};

  dual_channel_pwm_unit dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .freeze_mode(freeze_mode),
    .test_mode(test_mode), .ext_clk_pin(ext_clk_pin), .pwm_pin_a(pwm_pin_a),
    .pwm_pin_b(pwm_pin_b));

  // 10 MHz system clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // Hang guard; also makes an external clock with an 8-cycle period
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    ext_clk_pin <= cyc[2];
    if (cyc == 40000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h3);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  // Two snapshots taken 16 ticks apart must differ by exactly 16
  task automatic rate(input int p);
    rd(`OFS_COUNT);
    c0 = rv[15:0];
    repeat (16 * p - 4) @(posedge clk_sys);
    rd(`OFS_COUNT);
    chk("count_rate", {16'h0, rv[15:0] - c0}, 32'h0000_0010);
  endtask

  // Count write with the given mode straps, then read back
  task automatic cw(input logic f, input logic t, input logic [15:0] v);
    freeze_mode <= f;
    test_mode <= t;
    wr(`OFS_COUNT, {16'h0, v});
    freeze_mode <= 1'b0;
    test_mode <= 1'b0;
    rd(`OFS_COUNT);
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(`OFS_DUTY);
    chk("duty_rst", rv, 32'h0);
    rd(`OFS_CTRL);
    chk("ctrl_rst", rv, 32'h0);
    rd(`OFS_ACTIVE);
    chk("active_rst", rv, 32'h0);
    rate(2);
    // duty to high time, one period measured after two for the reload
    wr(`OFS_MODE, 32'h2);
    for (int i = 0; i < 5; i++) begin
      per = 512 << rows[i].ppr;
      wr(`OFS_CTRL, {29'h0, rows[i].ppr});
      wr(`OFS_DUTY, {24'h0, rows[i].duty});
      repeat (2 * per) @(posedge clk_sys);
      h = 0;
      repeat (per) begin
        @(posedge clk_sys);
        if (pwm_pin_b === 1'b1) h++;
      end
      chk("high_time", h, {16'h0, rows[i].high});
      rd(`OFS_ACTIVE);
      chk("active_b", rv, {24'h0, rows[i].duty});
    end
    // every tap and the external pin
    for (int k = 0; k < 8; k++) begin
      wr(`OFS_CTRL, k);
      rate((k == 7) ? 8 : (2 << k));
    end
    // count writes only in freeze or test mode; slow tap keeps it near
    wr(`OFS_CTRL, 32'h6);
    cw(1'b1, 1'b0, 16'h1234);
    chk("cnt_freeze", {17'h0, rv[15:1]}, 32'h091a);
    cw(1'b0, 1'b0, 16'h0000);
    chk("cnt_refuse", {17'h0, rv[15:1]}, 32'h091a);
    cw(1'b0, 1'b1, 16'h2222);
    chk("cnt_test", {17'h0, rv[15:1]}, 32'h1111);
    // unmapped, read-only buffer and byte lanes
    rd(8'h14);
    chk("unmapped", {31'h0, ev}, 32'h1);
    wr(`OFS_ACTIVE, 32'hffff);
    rd(`OFS_ACTIVE);
    chk("active_ro", rv, 32'h0001);
    apb(1'b1, `OFS_DUTY, 32'h0000abcd, 4'h2);
    rd(`OFS_DUTY);
    chk("duty_byte", rv, 32'h0000ab01);
    // slow slice uses count bits 14..7
    wr(`OFS_CTRL, 32'h1 << `SF_B_BIT);
    wr(`OFS_DUTY, 32'h80);
    cw(1'b0, 1'b1, 16'h7ff0);
    repeat (40) @(posedge clk_sys);
    cw(1'b0, 1'b1, 16'h01a0);
    chk("slow_high", pwm_pin_b, 1'b1);
    cw(1'b0, 1'b1, 16'h4120);
    chk("slow_low", pwm_pin_b, 1'b0);
    // disabled channel shows its force bit at once
    wr(`OFS_MODE, 32'h0);
    wr(`OFS_CTRL, 32'h100);
    repeat (2) @(posedge clk_sys);
    chk("gpio_a", pwm_pin_a, 1'b1);
    rd(`OFS_CTRL);
    chk("pin_rb", rv[9:8], 2'b01);
    // force waits for the running cycle to end
    wr(`OFS_MODE, 32'h3);
    wr(`OFS_CTRL, 32'h0);
    repeat (1100) @(posedge clk_sys);
    n = 0;
    do begin
      pv = pwm_pin_b;
      @(posedge clk_sys);
      n++;
    end while (!(pv === 1'b0 && pwm_pin_b === 1'b1) && n < 600);
    wr(`OFS_CTRL, 32'h100);
    chk("force_wait", pwm_pin_a, 1'b0);
    repeat (520) @(posedge clk_sys);
    chk("force_high", pwm_pin_a, 1'b1);
    // channel a shows the counter clock
    wr(`OFS_MODE, 32'h5);
    @(posedge clk_sys);
    h = 0;
    repeat (64) begin
      pv = pwm_pin_a;
      @(posedge clk_sys);
      if (pwm_pin_a !== pv) h++;
    end
    chk("clock_out", h, 32'h40);
    // second reset in mid-run clears count, duty and control
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk("pins_rst2", {pwm_pin_a, pwm_pin_b}, 2'h0);
    rd(`OFS_COUNT);
    chk("count_rst2", {18'h0, rv[15:2]}, 32'h0);
    rd(`OFS_DUTY);
    chk("duty_rst2", rv, 32'h0);
    rd(`OFS_CTRL);
    chk("ctrl_rst2", rv, 32'h0);
    end_of_test();
  end
endmodule
